// [src/ifmv_irq_ctrl.sv]
// Purpose: Interrupt flags, masks, global gate, vector sequencer and sleep wake-up.
// Assumes: mclk runs also in sleep; four mclk cycles form one instruction cycle.
// Notes:   Pins are synchronised before any flag logic looks at them.
//
// How it works
// RULE_01: Nine sources: pin edge, tick overflow, port change, six peripherals.
// RULE_02: Flags set on their event regardless of any enable bit.
// RULE_03: Global enable at control bit 7 passes unmasked requests, else blocks.
// RULE_04: With global enable set, flagged and enabled sources vector at once.
// RULE_05: Reset clears the global enable.
// RULE_06: Return-from-interrupt operation sets the global enable again.
// RULE_07: Taking an interrupt clears global enable, pushes return address, loads 0004h.
// RULE_08: Software clears serviced flags before re-enabling, or it re-enters.
// RULE_09: Pin and port-change latency is three or four instruction cycles.
// RULE_10: Pin edge polarity follows option bit 6; valid edge sets control bit 1.
// RULE_11: Clearing control bit 4 stops pin requests.
// RULE_12: Pin wakes from sleep only if its enable was set before sleep.
// RULE_13: Tick counter rollover FFh to 00h sets bit 2; enable at bit 5.
// RULE_14: Change on port B pins 7 to 4 sets bit 0, gated by its enable.
// RULE_15: Core flags sit in the control register with their enables.
// RULE_16: Peripheral flags and masks in own registers, plus group enable bit.
// RULE_17: Only the return address is saved on entry.
// RULE_18: Pin flag is sampled every first quarter phase.
// RULE_19: Software keeps peripheral bit 6 clear on the converterless variant.
// RULE_20: Wake with global enable set loads vector 0004h.
// RULE_21: Wake leaves the waking flag set.
// RULE_22: Enabled pending request wakes regardless of global enable.
// RULE_23: Request is global enable AND of core pairs OR group-gated peripheral pairs.
// RULE_24: Pin inputs pass two flip-flops before edge and change detection.
`timescale 1ns/10ps

module ifmv_irq_ctrl #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire ifmv_pkg::ifmv_addr_t reg_addr,
  input  wire ifmv_pkg::ifmv_byte_t reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output      ifmv_pkg::ifmv_byte_t reg_rdata,
  input  wire logic               ext_irq_pin,
  input  wire logic [3:0]         port_b_pins,
  input  wire ifmv_pkg::ifmv_byte_t timer_zero_count,
  input  wire logic [7:0]         periph_evt,
  input  wire ifmv_pkg::ifmv_pc_t core_pc,
  input  wire logic               core_sleeping,
  input  wire logic               return_from_isr_op,
  output      logic               first_quarter_phase,
  output      logic               core_irq_req,
  output      logic               wake_req,
  output      logic               isr_enter,
  output      logic               stack_push,
  output      ifmv_pkg::ifmv_pc_t stack_push_pc,
  output      ifmv_pkg::ifmv_pc_t pc_load_addr
);
  import ifmv_pkg::*;

  ifmv_byte_t      ctrl_r;
  ifmv_byte_t      pflag_r;
  ifmv_byte_t      pmask_r;
  ifmv_byte_t      option_r;
  ifmv_byte_t      periph_impl;
  logic [1:0]      phase_r;
  logic            pin_s1_r;
  logic            pin_s2_r;
  logic            pin_s3_r;
  logic [3:0]      pb_s1_r;
  logic [3:0]      pb_s2_r;
  logic [3:0]      pb_s3_r;
  ifmv_byte_t      t0_prev_r;
  logic            ext_pin_enable_at_sleep_r;
  logic            sleep_prev_r;
  logic            pin_edge;
  logic            pb_change;
  logic            t0_wrap;
  logic            core_pend;
  logic            periph_pend;
  logic            any_pend;
  logic            pin_wake_ok;
  logic            take_vec;
  ifmv_seq_t       seq_r;

  // Without the converter its flag and mask bit are never implemented.
  assign periph_impl = HAS_CONVERTER ? `IFMV_PERIPH_IMPL
                                     : (`IFMV_PERIPH_IMPL & ~`IFMV_PERIPH_CONV);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= `IFMV_PHASE_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign first_quarter_phase = (phase_r == `IFMV_PHASE_Q1);

  // The second and third stages feed detection; the third holds the previous sample.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      pb_s1_r  <= 4'h0;
      pb_s2_r  <= 4'h0;
      pb_s3_r  <= 4'h0;
    end else begin
      pin_s1_r <= ext_irq_pin; // RULE_24
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pb_s1_r  <= port_b_pins; // RULE_24
      pb_s2_r  <= pb_s1_r;
      pb_s3_r  <= pb_s2_r;
    end
  end

  assign pin_edge  = option_r[`IFMV_OPT_EDGE] ? (pin_s2_r & ~pin_s3_r)
                                              : (~pin_s2_r & pin_s3_r); // RULE_10
  assign pb_change = |(pb_s2_r ^ pb_s3_r); // RULE_14

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      t0_prev_r <= `IFMV_T0_MIN;
    end else begin
      t0_prev_r <= timer_zero_count;
    end
  end

  assign t0_wrap = (t0_prev_r == `IFMV_T0_MAX) && (timer_zero_count == `IFMV_T0_MIN); // RULE_13

  // Control register: a hardware set wins over a software clear in the same cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `IFMV_CTRL_RST; // RULE_05
    end else begin
      ifmv_byte_t ctrl_nxt;
      ctrl_nxt = ctrl_r;
      if (reg_wr && reg_addr == `IFMV_OFF_CTRL) begin
        ctrl_nxt = reg_wdata;
      end
      if (return_from_isr_op) begin
        ctrl_nxt[`IFMV_CTRL_GLB_EN] = 1'b1; // RULE_06
      end
      if (take_vec) begin
        ctrl_nxt[`IFMV_CTRL_GLB_EN] = 1'b0; // RULE_07
      end
      if (pin_edge) begin
        ctrl_nxt[`IFMV_CTRL_PIN_FLG] = 1'b1; // RULE_02 RULE_10
      end
      if (t0_wrap) begin
        ctrl_nxt[`IFMV_CTRL_TICK_FLG] = 1'b1; // RULE_02 RULE_13
      end
      if (pb_change) begin
        ctrl_nxt[`IFMV_CTRL_CHG_FLG] = 1'b1; // RULE_02 RULE_14
      end
      ctrl_r <= ctrl_nxt; // RULE_15
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pflag_r <= `IFMV_PERIPH_RST;
    end else begin
      ifmv_byte_t pflag_nxt;
      pflag_nxt = pflag_r;
      if (reg_wr && reg_addr == `IFMV_OFF_PFLAG) begin
        pflag_nxt = reg_wdata;
      end
      pflag_r <= (pflag_nxt | periph_evt) & periph_impl; // RULE_01 RULE_02 RULE_16
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pmask_r  <= `IFMV_PERIPH_RST;
      option_r <= `IFMV_OPTION_RST;
    end else begin
      if (reg_wr && reg_addr == `IFMV_OFF_PMASK) begin
        pmask_r <= reg_wdata & periph_impl; // RULE_16
      end
      if (reg_wr && reg_addr == `IFMV_OFF_OPTION) begin
        option_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `IFMV_OFF_CTRL:   reg_rdata <= ctrl_r;
        `IFMV_OFF_PFLAG:  reg_rdata <= pflag_r;
        `IFMV_OFF_PMASK:  reg_rdata <= pmask_r;
        `IFMV_OFF_OPTION: reg_rdata <= option_r;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // The pin is only sampled for recognition at the first quarter phase.
  assign core_pend = (ctrl_r[`IFMV_CTRL_PIN_FLG] & ctrl_r[`IFMV_CTRL_PIN_EN]) // RULE_11 RULE_18
                   | (ctrl_r[`IFMV_CTRL_TICK_FLG] & ctrl_r[`IFMV_CTRL_TICK_EN])
                   | (ctrl_r[`IFMV_CTRL_CHG_FLG] & ctrl_r[`IFMV_CTRL_CHG_EN]);
  assign periph_pend = ctrl_r[`IFMV_CTRL_PEIE] & (|(pflag_r & pmask_r)); // RULE_16
  assign any_pend    = core_pend | periph_pend;
  assign core_irq_req = ctrl_r[`IFMV_CTRL_GLB_EN] & any_pend; // RULE_03 RULE_23

  // The pin enable is captured as sleep begins, so a later enable cannot wake.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_prev_r    <= 1'b0;
      ext_pin_enable_at_sleep_r <= 1'b0;
    end else begin
      sleep_prev_r <= core_sleeping;
      if (core_sleeping && !sleep_prev_r) begin
        ext_pin_enable_at_sleep_r <= ctrl_r[`IFMV_CTRL_PIN_EN]; // RULE_12
      end
    end
  end

  assign pin_wake_ok = ctrl_r[`IFMV_CTRL_PIN_FLG] & ctrl_r[`IFMV_CTRL_PIN_EN] & ext_pin_enable_at_sleep_r;
  assign wake_req = core_sleeping & (pin_wake_ok // RULE_12 RULE_21 RULE_22
                  | (ctrl_r[`IFMV_CTRL_TICK_FLG] & ctrl_r[`IFMV_CTRL_TICK_EN])
                  | (ctrl_r[`IFMV_CTRL_CHG_FLG] & ctrl_r[`IFMV_CTRL_CHG_EN])
                  | periph_pend);

  // Two full instruction cycles pass between recognition and the vector, so a
  // pin event reaches the vector in three to four instruction cycles whatever
  // the length of the current instruction.
  assign take_vec = (seq_r == IFMV_SEQ_VEC) && first_quarter_phase; // RULE_04 RULE_09

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seq_r <= IFMV_SEQ_IDLE;
    end else begin
      unique case (seq_r)
        IFMV_SEQ_IDLE: begin
          if (first_quarter_phase && core_irq_req && !core_sleeping) begin
            seq_r <= IFMV_SEQ_WAIT; // RULE_18 RULE_20
          end
        end
        IFMV_SEQ_WAIT: begin
          if (first_quarter_phase) begin
            seq_r <= IFMV_SEQ_VEC;
          end
        end
        IFMV_SEQ_VEC: begin
          if (first_quarter_phase) begin
            seq_r <= IFMV_SEQ_IDLE;
          end
        end
        default: begin
          seq_r <= IFMV_SEQ_IDLE;
        end
      endcase
    end
  end

  // Only the return address is handed to the stack; other context is software's.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      isr_enter     <= 1'b0;
      stack_push    <= 1'b0;
      stack_push_pc <= '0;
      pc_load_addr  <= '0;
    end else begin
      isr_enter  <= take_vec; // RULE_07
      stack_push <= take_vec; // RULE_17
      if (take_vec) begin
        stack_push_pc <= core_pc;
        pc_load_addr  <= `IFMV_VECTOR; // RULE_07 RULE_20
      end
    end
  end

endmodule : ifmv_irq_ctrl

// [src/ifmv_params.svh]
// Purpose: Named constants for the interrupt flag, mask and vector logic.
// Assumes: Eight-bit register port; four master clocks make one instruction cycle.
// Notes:   Offsets are word indices on the plain register port.
`ifndef IFMV_PARAMS_SVH
`define IFMV_PARAMS_SVH

`define IFMV_ADDR_W        2
`define IFMV_OFF_CTRL      2'h0
`define IFMV_OFF_PFLAG     2'h1
`define IFMV_OFF_PMASK     2'h2
`define IFMV_OFF_OPTION    2'h3

`define IFMV_CTRL_GLB_EN   7
`define IFMV_CTRL_PEIE     6
`define IFMV_CTRL_TICK_EN  5
`define IFMV_CTRL_PIN_EN   4
`define IFMV_CTRL_CHG_EN   3
`define IFMV_CTRL_TICK_FLG 2
`define IFMV_CTRL_PIN_FLG  1
`define IFMV_CTRL_CHG_FLG  0
`define IFMV_OPT_EDGE      6

`define IFMV_CTRL_RST      8'h00
`define IFMV_PERIPH_RST    8'h00
`define IFMV_OPTION_RST    8'hff
`define IFMV_PERIPH_IMPL   8'hcf
`define IFMV_PERIPH_CONV   8'h40
`define IFMV_T0_MAX        8'hff
`define IFMV_T0_MIN        8'h00

`define IFMV_PC_W          13
`define IFMV_VECTOR        13'h0004
`define IFMV_PHASE_Q1      2'h0
`define IFMV_PHASE_Q4      2'h3

`endif

// [src/ifmv_pkg.sv]
// Purpose: Types shared by the interrupt flag, mask and vector logic.
// Assumes: Constants come from ifmv_params.svh.
// Notes:   The sequencer state codes are one-hot.
`include "ifmv_params.svh"

package ifmv_pkg;

  typedef logic [`IFMV_ADDR_W-1:0] ifmv_addr_t;
  typedef logic [7:0]              ifmv_byte_t;
  typedef logic [`IFMV_PC_W-1:0]   ifmv_pc_t;

  typedef enum logic [2:0] {
    IFMV_SEQ_IDLE = 3'b001,
    IFMV_SEQ_WAIT = 3'b010,
    IFMV_SEQ_VEC  = 3'b100
  } ifmv_seq_t;

endpackage : ifmv_pkg

// [dv/ifmv_chk.sv]
// Purpose: Port assertions for the interrupt flag, mask and vector block.
// Assumes: Four mclk make one instruction cycle.
// Notes:   Bound to every ifmv_irq_ctrl instance.
`timescale 1ns/10ps
`include "ifmv_params.svh"
module ifmv_chk (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire ifmv_pkg::ifmv_addr_t reg_addr,
  input wire logic                 reg_rd,
  input wire ifmv_pkg::ifmv_byte_t reg_rdata,
  input wire ifmv_pkg::ifmv_pc_t   core_pc,
  input wire logic                 core_sleeping,
  input wire logic                 first_quarter_phase,
  input wire logic                 core_irq_req,
  input wire logic                 wake_req,
  input wire logic                 isr_enter,
  input wire logic                 stack_push,
  input wire ifmv_pkg::ifmv_pc_t   stack_push_pc,
  input wire ifmv_pkg::ifmv_pc_t   pc_load_addr
);
  import ifmv_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_phase;
    first_quarter_phase |=> !first_quarter_phase [*3] ##1 first_quarter_phase;
  endproperty
  a_phase: assert property (p_phase) else $error("phase not one in four");
  property p_take;
    core_irq_req && first_quarter_phase && !core_sleeping |-> ##[1:9] isr_enter;
  endproperty
  a_take: assert property (p_take) else $error("request not vectored");
  property p_gie_off;
    isr_enter |-> !core_irq_req;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("gate open on entry");
  property p_vec;
    isr_enter |-> stack_push && pc_load_addr == `IFMV_VECTOR;
  endproperty
  a_vec: assert property (p_vec) else $error("bad push or vector");
  property p_push_pc;
    isr_enter |-> stack_push_pc == $past(core_pc);
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("wrong return address");
  property p_held;
    !isr_enter |-> $stable(stack_push_pc);
  endproperty
  a_held: assert property (p_held) else $error("return address moved");
  property p_pulse;
    isr_enter |=> !isr_enter && !stack_push;
  endproperty
  a_pulse: assert property (p_pulse) else $error("entry pulse too long");
  property p_wake;
    wake_req |-> core_sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_rsv;
    reg_rd && (reg_addr == `IFMV_OFF_PFLAG || reg_addr == `IFMV_OFF_PMASK)
      |=> reg_rdata[5:4] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("unimplemented bits set");
  c_take: cover property (isr_enter);
  c_wake: cover property (wake_req);
  c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : ifmv_chk

bind ifmv_irq_ctrl ifmv_chk i_ifmv_chk (.mclk, .rst, .reg_addr, .reg_rd, .reg_rdata,
  .core_pc, .core_sleeping, .first_quarter_phase, .core_irq_req, .wake_req,
  .isr_enter, .stack_push, .stack_push_pc, .pc_load_addr);

// [dv/ifmv_core_model.sv]
// Purpose: Behavioural core sequencer facing the interrupt block.
// Assumes: Program counter advances once per instruction cycle.
// Notes:   Sleep and return are commanded by the bench.
`timescale 1ns/10ps
module ifmv_core_model (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               first_quarter_phase,
  input  wire logic               isr_enter,
  input  wire logic               wake_req,
  input  wire ifmv_pkg::ifmv_pc_t pc_load_addr,
  input  wire logic               sleep_cmd,
  input  wire logic               ret_cmd,
  output      ifmv_pkg::ifmv_pc_t core_pc,
  output      logic               core_sleeping,
  output      logic               return_from_isr_op
);
  import ifmv_pkg::*;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) core_pc <= 13'h0000;
    else if (isr_enter) core_pc <= pc_load_addr;
    else if (first_quarter_phase && !core_sleeping) core_pc <= core_pc + 13'h0001;
  end
  // A wake ends sleep even with the global gate shut; the pc simply resumes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) core_sleeping <= 1'b0;
    else if (wake_req) core_sleeping <= 1'b0;
    else if (sleep_cmd) core_sleeping <= 1'b1;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) return_from_isr_op <= 1'b0;
    else return_from_isr_op <= ret_cmd;
  end
endmodule : ifmv_core_model

// [dv/tb.sv]
// Purpose: Directed bench for the interrupt flag, mask and vector block.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Pins are held long enough to pass the synchroniser.
`timescale 1ns/10ps
module tb;
  import ifmv_pkg::*;
  logic       mclk, rst, reg_wr, reg_rd, ext_irq_pin, sleep_cmd, ret_cmd;
  logic       core_sleeping, return_from_isr_op, first_quarter_phase;
  logic       core_irq_req, wake_req, isr_enter, stack_push;
  logic [7:0] periph_evt;
  logic [3:0] port_b_pins;
  ifmv_addr_t reg_addr;
  ifmv_byte_t reg_wdata, reg_rdata, timer_zero_count;
  ifmv_pc_t   core_pc, stack_push_pc, pc_load_addr;
  int         failures, samples_checked, cyc, n;
  ifmv_irq_ctrl i_ifmv_irq_ctrl (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq_pin, .port_b_pins, .timer_zero_count, .periph_evt, .core_pc,
    .core_sleeping, .return_from_isr_op, .first_quarter_phase, .core_irq_req,
    .wake_req, .isr_enter, .stack_push, .stack_push_pc, .pc_load_addr);
  ifmv_core_model i_ifmv_core_model (.mclk, .rst, .first_quarter_phase, .isr_enter,
    .wake_req, .pc_load_addr, .sleep_cmd, .ret_cmd, .core_pc, .core_sleeping,
    .return_from_isr_op);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(string nm, logic [12:0] seen, logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(ifmv_addr_t a, ifmv_byte_t d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(string nm, ifmv_addr_t a, ifmv_byte_t exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask : rdc
  task automatic pin(logic v);
    @(posedge mclk);
    ext_irq_pin <= v;
    repeat (8) @(posedge mclk);
  endtask : pin
  // Bounded wait so a missing response cannot hang the run.
  task automatic wait_hi(bit wake, output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      #1;
      cnt++;
    end while ((wake ? wake_req : isr_enter) !== 1'b1 && cnt < 40);
  endtask : wait_hi
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    {reg_wr, reg_rd, ext_irq_pin, sleep_cmd, ret_cmd, reg_addr} = '0;
    {reg_wdata, timer_zero_count, periph_evt, port_b_pins} = '0;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc("reset", 2'(i), i == 3 ? 8'hff : 8'h00);
    pin(1'b1);
    rdc("pin flag", 2'h0, 8'h02);
    chk("req gated", core_irq_req, 1'b0);
    @(posedge mclk) timer_zero_count <= 8'hff;
    @(posedge mclk) timer_zero_count <= 8'h00;
    rdc("tick flag", 2'h0, 8'h06);
    @(posedge mclk) port_b_pins <= 4'h8;
    repeat (8) @(posedge mclk);
    rdc("change flag", 2'h0, 8'h07);
    @(posedge mclk) periph_evt <= 8'hff;
    @(posedge mclk) periph_evt <= 8'h00;
    rdc("periph flags", 2'h1, 8'hcf);
    wr(2'h2, 8'hff);
    rdc("periph masks", 2'h2, 8'hcf);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
    pin(1'b0);
    rdc("wrong edge", 2'h0, 8'h00);
    wr(2'h0, 8'h80);
    @(posedge mclk) periph_evt <= 8'h01;
    @(posedge mclk) periph_evt <= 8'h00;
    pin(1'b1);
    chk("group gate", core_irq_req, 1'b0);
    rdc("pin masked", 2'h0, 8'h82);
    wr(2'h0, 8'hc0);
    wait_hi(1'b0, n);
    chk("periph take", isr_enter, 1'b1);
    chk("vector", pc_load_addr, 13'h0004);
    rdc("gate cleared", 2'h0, 8'h40);
    wr(2'h1, 8'h00);
    @(posedge mclk) ret_cmd <= 1'b1;
    @(posedge mclk) ret_cmd <= 1'b0;
    rdc("gate restored", 2'h0, 8'hc0);
    wr(2'h0, 8'h90);
    pin(1'b0);
    @(posedge mclk) ext_irq_pin <= 1'b1;
    wait_hi(1'b0, n);
    chk("latency", n inside {[12:16]}, 1'b1);
    rdc("pin take", 2'h0, 8'h12);
    wr(2'h0, 8'h10);
    @(posedge mclk) sleep_cmd <= 1'b1;
    @(posedge mclk) sleep_cmd <= 1'b0;
    pin(1'b0);
    @(posedge mclk) ext_irq_pin <= 1'b1;
    wait_hi(1'b1, n);
    chk("wake", wake_req, 1'b1);
    n = 0;
    repeat (12) begin
      @(posedge mclk);
      #1;
      n += int'(isr_enter === 1'b1);
    end
    chk("no vector", n, 0);
    rdc("wake source", 2'h0, 8'h12);
    wr(2'h3, 8'hbf);
    wr(2'h0, 8'h00);
    pin(1'b0);
    rdc("falling edge", 2'h0, 8'h02);
    finish_test();
  end
endmodule : tb
